// ==== ssd_defines.svh ====
// constants for the serial-programmed synthesizer divider core
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH
`define SSD_SR_W 18
`define SSD_DATA_W 17
`define SSD_ADDR_BIT 0
`define SSD_REF_VAL_MSB 9
`define SSD_REF_VAL_LSB 0
`define SSD_REF_FLOAT_BIT 10
`define SSD_REF_POL_BIT 11
`define SSD_REF_RSV_BIT 12
`define SSD_REF_TEST_BIT 13
`define SSD_FB_MAIN_MSB 16
`define SSD_FB_MAIN_LSB 7
`define SSD_FB_SWAL_MSB 6
`define SSD_FB_SWAL_LSB 2
`define SSD_FB_CTRL_MSB 1
`define SSD_FB_CTRL_LSB 0
`define SSD_REF_LATCH_RST 17'h0_0400
`define SSD_FB_LATCH_RST 17'h0_0000
`define SSD_PRESC_MOD 32
`define SSD_PD_BIT_POS 0
`endif

// ==== ssd_pkg.sv ====
// types for the synthesizer divider core
package ssd_pkg;
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_LEAD_REF,
    PFD_LEAD_FB
  } ssd_pfd_state_t;
  typedef logic [16:0] ssd_latch_t;
endpackage

// ==== ssd_cnt.sv ====
// wrapping up-counter used by the reference, prescaler and main dividers
`timescale 1ns/1ps
module ssd_cnt #(
  parameter int W = 10
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic step_i,
  input wire logic [W-1:0] limit_i,
  output logic [W-1:0] count_o,
  output logic wrap_o
);
  logic [W-1:0] count_q;

  assign wrap_o = step_i & (count_q == limit_i);
  assign count_o = count_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || clr_i) begin
      count_q <= '0;
    end else if (step_i) begin
      count_q <= wrap_o ? '0 : count_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // ssd_cnt

// ==== ssd_core.sv ====
// serial-programmed reference/feedback divider and phase detector core
`timescale 1ns/1ps
`include "ssd_defines.svh"
module ssd_core #(
  parameter int PRESC_MOD = `SSD_PRESC_MOD,
  parameter int PD_BIT_POS = `SSD_PD_BIT_POS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  input wire logic ref_clock_in_i,
  input wire logic rf_input_i,
  output logic pump_up_o,
  output logic pump_down_o,
  output logic pump_output_o,
  output logic pump_output_oe_n_o,
  output logic powered_down_o
);
  import ssd_pkg::*;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  logic ser_clk_q, load_q, ref_in_q, rf_in_q;
  logic [`SSD_SR_W-1:0] shift_q;
  ssd_pkg::ssd_latch_t ref_latch_q, fb_latch_q;
  ssd_pkg::ssd_pfd_state_t pfd_q;
  logic [4:0] swal_rem_q;
  logic ref_out_q, fb_out_q;

  // inputs are synchronous to clock_i; edges are found against last sample
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ser_clk_q <= 1'b0;
      load_q <= 1'b0;
      ref_in_q <= 1'b0;
      rf_in_q <= 1'b0;
    end else if (clk_en_i) begin
      ser_clk_q <= ser_clk_i;
      load_q <= load_strobe_i;
      ref_in_q <= ref_clock_in_i;
      rf_in_q <= rf_input_i;
    end
  end

  logic ser_rise, load_rise, ref_rise, rf_rise;
  assign ser_rise = clk_en_i & ser_clk_i & ~ser_clk_q;
  assign load_rise = clk_en_i & load_strobe_i & ~load_q;
  assign ref_rise = clk_en_i & ref_clock_in_i & ~ref_in_q;
  assign rf_rise = clk_en_i & rf_input_i & ~rf_in_q;

  // serial path ignores power-down so settings can be loaded while asleep
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      shift_q <= '0;
    end else if (ser_rise) begin
      shift_q <= {shift_q[`SSD_SR_W-2:0], ser_data_i};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_latch_q <= `SSD_REF_LATCH_RST;
      fb_latch_q <= `SSD_FB_LATCH_RST;
    end else if (load_rise) begin
      if (shift_q[`SSD_ADDR_BIT]) begin
        ref_latch_q <= shift_q[`SSD_SR_W-1:1];
      end else begin
        fb_latch_q <= shift_q[`SSD_SR_W-1:1];
      end
    end
  end

  logic [9:0] ref_div_value, main_count;
  logic [4:0] swallow_count;
  logic [1:0] control_pair;
  logic pump_float, detector_polarity, reserved_bit, test_mode, powerdown_bit;
  assign ref_div_value = ref_latch_q[`SSD_REF_VAL_MSB:`SSD_REF_VAL_LSB];
  assign pump_float = ref_latch_q[`SSD_REF_FLOAT_BIT];
  assign detector_polarity = ref_latch_q[`SSD_REF_POL_BIT];
  assign reserved_bit = ref_latch_q[`SSD_REF_RSV_BIT];
  assign test_mode = ref_latch_q[`SSD_REF_TEST_BIT];
  assign main_count = fb_latch_q[`SSD_FB_MAIN_MSB:`SSD_FB_MAIN_LSB];
  assign swallow_count = fb_latch_q[`SSD_FB_SWAL_MSB:`SSD_FB_SWAL_LSB];
  assign control_pair = fb_latch_q[`SSD_FB_CTRL_MSB:`SSD_FB_CTRL_LSB];
  assign powerdown_bit = control_pair[PD_BIT_POS];

  // chip enable low wins over the programmed bit
  logic pd;
  assign pd = ~chip_enable_i | powerdown_bit;

  // clears are gated as well, so a low clock enable freezes every counter
  logic pd_clr;
  assign pd_clr = clk_en_i & pd;

  // all dividers clear while powered down and restart on the same edge,
  // so the feedback chain is off by at most one prescaler period on wake-up
  logic [9:0] ref_cnt, main_cnt;
  logic ref_wrap, presc_wrap, fb_wrap;
  logic [5:0] presc_limit;
  assign presc_limit = (swal_rem_q != 5'h00) ? 6'(PRESC_MOD) : 6'(PRESC_MOD - 1);

  ssd_cnt #(.W(10)) u_ref_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(pd_clr),
    .step_i(ref_rise),
    .limit_i(ref_div_value - 10'h001),
    .count_o(ref_cnt),
    .wrap_o(ref_wrap)
  );

  ssd_cnt #(.W(6)) u_prescaler (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(pd_clr),
    .step_i(rf_rise),
    .limit_i(presc_limit),
    .count_o(),
    .wrap_o(presc_wrap)
  );

  ssd_cnt #(.W(10)) u_main_div (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(pd_clr),
    .step_i(presc_wrap),
    .limit_i(main_count - 10'h001),
    .count_o(main_cnt),
    .wrap_o(fb_wrap)
  );

  // swallow counter keeps the prescaler at modulus+1 for its first cycles
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      swal_rem_q <= '0;
    end else if (pd_clr || fb_wrap) begin
      swal_rem_q <= swallow_count;
    end else if (presc_wrap && swal_rem_q != 5'h00) begin
      swal_rem_q <= swal_rem_q - 5'h01;
    end
  end

  // divider outputs as square-ish levels for the test path
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || pd_clr) begin
      ref_out_q <= 1'b0;
      fb_out_q <= 1'b0;
    end else begin
      if (ref_wrap) begin
        ref_out_q <= ~ref_out_q;
      end
      if (fb_wrap) begin
        fb_out_q <= ~fb_out_q;
      end
    end
  end

  // phase/frequency detector: the first divider edge opens a window,
  // the other one closes it, simultaneous edges cancel
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || pd_clr) begin
      pfd_q <= PFD_IDLE;
    end else begin
      case (pfd_q)
        PFD_IDLE: begin
          if (ref_wrap && !fb_wrap) begin
            pfd_q <= PFD_LEAD_REF;
          end else if (fb_wrap && !ref_wrap) begin
            pfd_q <= PFD_LEAD_FB;
          end
        end
        PFD_LEAD_REF: begin
          if (fb_wrap) begin
            pfd_q <= PFD_IDLE;
          end
        end
        PFD_LEAD_FB: begin
          if (ref_wrap) begin
            pfd_q <= PFD_IDLE;
          end
        end
        default: pfd_q <= PFD_IDLE;
      endcase
    end
  end

  logic want_up, want_down;
  assign want_up = detector_polarity ? (pfd_q == PFD_LEAD_REF) : (pfd_q == PFD_LEAD_FB);
  assign want_down = detector_polarity ? (pfd_q == PFD_LEAD_FB) : (pfd_q == PFD_LEAD_REF);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
      pump_output_o <= 1'b0;
      pump_output_oe_n_o <= 1'b1;
      powered_down_o <= 1'b0;
    end else if (clk_en_i) begin
      powered_down_o <= pd;
      pump_up_o <= ~pd & ~pump_float & want_up;
      pump_down_o <= ~pd & ~pump_float & want_down;
      if (pd) begin
        pump_output_o <= 1'b0;
        pump_output_oe_n_o <= 1'b1;
      end else if (test_mode && pump_float) begin
        pump_output_o <= detector_polarity ? fb_out_q : ref_out_q;
        pump_output_oe_n_o <= 1'b0;
      end else if (pump_float || !(want_up || want_down)) begin
        pump_output_o <= 1'b0;
        pump_output_oe_n_o <= 1'b1;
      end else begin
        pump_output_o <= want_up;
        pump_output_oe_n_o <= 1'b0;
      end
    end
  end

  property p_shift;
    ser_rise |=> shift_q == {$past(shift_q[16:0]), $past(ser_data_i)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not take serial bit");

  property p_load_ref;
    load_rise && shift_q[0] |=> ref_latch_q == $past(shift_q[17:1]) && $stable(fb_latch_q);
  endproperty
  a_load_ref: assert property (p_load_ref) else $error("reference latch load wrong");

  property p_load_fb;
    load_rise && !shift_q[0] |=> fb_latch_q == $past(shift_q[17:1]) && $stable(ref_latch_q);
  endproperty
  a_load_fb: assert property (p_load_fb) else $error("feedback latch load wrong");

  property p_hold;
    !load_rise |=> $stable(ref_latch_q) && $stable(fb_latch_q);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without load");

  property p_pd_float;
    clk_en_i && pd |=> pump_output_oe_n_o && !pump_up_o && !pump_down_o && powered_down_o;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("pump not floated in power-down");

  property p_pd_clear;
    pd_clr |=> ref_cnt == 10'h000 && main_cnt == 10'h000 && pfd_q == PFD_IDLE;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("counters not cleared in power-down");

  property p_test_ref;
    clk_en_i && !pd && test_mode && pump_float && !detector_polarity
      |=> !pump_output_oe_n_o && pump_output_o == $past(ref_out_q);
  endproperty
  a_test_ref: assert property (p_test_ref) else $error("test mode did not route reference");

  property p_pump_up;
    clk_en_i && !pd && !pump_float && detector_polarity && pfd_q == PFD_LEAD_REF
      |=> pump_up_o && pump_output_o && !pump_output_oe_n_o;
  endproperty
  a_pump_up: assert property (p_pump_up) else $error("pump up not driven");

  property p_swallow;
    !pd && !fb_wrap && presc_wrap && swal_rem_q != 5'h00 |=> swal_rem_q == $past(swal_rem_q) - 5'h01;
  endproperty
  a_swallow: assert property (p_swallow) else $error("swallow count did not step");
endmodule // ssd_core

// ==== ssd_host_model.sv ====
// host controller model driving the three-wire programming bus
`timescale 1ns/1ps
module ssd_host_model (
  input wire logic clock_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // serial clock rests low between frames; data goes to the inverse once released
  task automatic send(input logic [17:0] w, input logic strobe);
    for (int i = 17; i >= 0; i--) begin
      @(negedge clock_i);
      ser_clk_o = 1'b0;
      ser_data_o = w[i];
      @(negedge clock_i);
      ser_clk_o = 1'b1;
    end
    @(negedge clock_i);
    ser_clk_o = 1'b0;
    ser_data_o = ~w[0];
    if (strobe) begin
      @(negedge clock_i);
      load_strobe_o = 1'b1;
      @(negedge clock_i);
      load_strobe_o = 1'b0;
    end
    @(negedge clock_i);
  endtask
endmodule // ssd_host_model

// ==== tb.sv ====
// self-checking bench for the synthesizer divider core
`timescale 1ns/1ps
module tb;
  localparam int PD_POS = 0;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic chip_enable_i = 1'b1;
  logic ref_clk = 1'b0;
  logic rf_clk = 1'b0;
  logic ref_run = 1'b0;
  logic rf_run = 1'b0;
  logic ser_clk, ser_data, load_strobe;
  logic pump_up_o, pump_down_o, pump_output_o, pump_output_oe_n_o, powered_down_o;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  int rv[3] = '{2, 5, 1023};
  initial forever #25 clock_i = ~clock_i;
  ssd_host_model host (.clock_i(clock_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(load_strobe));
  ssd_core #(.PRESC_MOD(32), .PD_BIT_POS(PD_POS)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .ser_clk_i(ser_clk),
    .ser_data_i(ser_data), .load_strobe_i(load_strobe), .chip_enable_i(chip_enable_i),
    .ref_clock_in_i(ref_clk), .rf_input_i(rf_clk), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o),
    .pump_output_o(pump_output_o), .pump_output_oe_n_o(pump_output_oe_n_o), .powered_down_o(powered_down_o));
  // both oscillators toggle every cycle, so one rising edge per two clocks
  always @(negedge clock_i) begin
    if (ref_run) ref_clk <= ~ref_clk;
    if (rf_run) rf_clk <= ~rf_clk;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic [17:0] ref_word(logic tst, logic pol, logic flt, logic [9:0] r);
    return {3'b000, tst, 1'b0, pol, flt, r, 1'b1};
  endfunction
  function automatic logic [17:0] fb_word(logic [9:0] b, logic [4:0] a, logic [1:0] c);
    return {b, a, c, 1'b0};
  endfunction
  // skips the first two toggles, whose phase depends on when the load landed
  task automatic measure(output int cnt);
    logic p;
    int k;
    cnt = 0;
    for (int e = 0; e < 2; e++) begin
      p = pump_output_o;
      k = 0;
      while (pump_output_o === p && k < 5000) begin
        @(negedge clock_i);
        k++;
      end
    end
    p = pump_output_o;
    while (pump_output_o === p && cnt < 5000) begin
      @(negedge clock_i);
      cnt++;
    end
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check("oe_n_reset", pump_output_oe_n_o, 1);
    check("up_reset", {pump_up_o, pump_down_o, powered_down_o}, 0);
    ref_run = 1'b1;
    // divide values keep the detector rate well below its limit
    host.send(fb_word(10'd3, 5'd1, 2'b00), 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.send(ref_word(1, 0, 1, 10'(rv[i])), 1'b1);
      measure(n);
      check("ref_period", n, 2 * rv[i]);
    end
    check("oe_n_test", pump_output_oe_n_o, 0);
    rf_run = 1'b1;
    host.send(ref_word(1, 1, 1, 10'd2), 1'b1);
    measure(n);
    check("fb_period_3_1", n, 2 * (32 * 3 + 1));
    host.send(fb_word(10'd4, 5'd2, 2'b00), 1'b1);
    measure(n);
    check("fb_period_4_2", n, 2 * (32 * 4 + 2));
    host.send(fb_word(10'd9, 5'd0, 2'b00), 1'b0);
    measure(n);
    check("fb_no_strobe", n, 2 * (32 * 4 + 2));
    chip_enable_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check("pd_pin", powered_down_o, 1);
    check("oe_n_pd_pin", pump_output_oe_n_o, 1);
    host.send(ref_word(1, 0, 1, 10'd3), 1'b1);
    chip_enable_i = 1'b1;
    measure(n);
    check("ref_after_pd", n, 6);
    host.send(fb_word(10'd4, 5'd2, 2'(1 << PD_POS)), 1'b1);
    repeat (3) @(negedge clock_i);
    check("pd_bit", powered_down_o, 1);
    check("oe_n_pd_bit", pump_output_oe_n_o, 1);
    host.send(fb_word(10'd4, 5'd2, 2'b00), 1'b1);
    repeat (3) @(negedge clock_i);
    check("pd_bit_clear", powered_down_o, 0);
    rf_run = 1'b0;
    // same ratio as before, so the running count never overshoots the new limit
    host.send(ref_word(0, 1, 0, 10'd3), 1'b1);
    repeat (20) @(negedge clock_i);
    check("pos_up", {pump_up_o, pump_down_o, pump_output_o, pump_output_oe_n_o}, 4'b1010);
    host.send(ref_word(0, 0, 0, 10'd3), 1'b1);
    repeat (20) @(negedge clock_i);
    check("neg_down", {pump_up_o, pump_down_o, pump_output_o, pump_output_oe_n_o}, 4'b0100);
    results();
  end
endmodule // tb
